// ---- hw/snf_defs.vh ----
// Purpose: Constants for the nibble FIFO host controller
// Assumes: 40 MHz core clock
// Notes: Times in ns, cycle counts derived
`ifndef SNF_DEFS_VH
`define SNF_DEFS_VH
`define SNF_CLK_PERIOD_NS 25
`define SNF_WORD_W 4
`define SNF_DEPTH 64
`define SNF_BUF_DEPTH 8
`define SNF_BUF_AW 3
`define SNF_SETTLE_NS 250
`define SNF_SETTLE_CYC ((`SNF_SETTLE_NS + `SNF_CLK_PERIOD_NS - 1) / `SNF_CLK_PERIOD_NS)
`define SNF_TRANSIT_MAX_NS 32000
`define SNF_TRANSIT_MAX_CYC (`SNF_TRANSIT_MAX_NS / `SNF_CLK_PERIOD_NS)
`define SNF_CNT_W 11
`endif

// ---- hw/snf_stream_buffer.v ----
// Purpose: Small valid/ready FIFO in the write data path
// Assumes: Single clock, synchronous reset
// Notes: Width and depth are parameters
`timescale 1ns/10ps
module snf_stream_buffer #(
   parameter WIDTH = 4,
   parameter DEPTH = 8,
   parameter AW = 3
)
(
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Fill side
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // Drain side
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr;
   reg [AW-1:0] rdPtr;
   reg [AW:0] count;
   wire doWrite;
   wire doRead;
   assign inReady = (count != DEPTH[AW:0]);
   assign outValid = (count != {(AW+1){1'b0}});
   assign outData = mem[rdPtr];
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;
   always @(posedge core_clk)
   begin
      if (doWrite)
      begin
         mem[wrPtr] <= inData;
      end
   end
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end
      else
      begin
         if (doWrite)
         begin
            wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
         end
         if (doRead)
         begin
            rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
         end
         if (doWrite && !doRead)
         begin
            count <= count + 1'b1;
         end
         else if (doRead && !doWrite)
         begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// ---- hw/snf_host_ctrl.v ----
// Purpose: Host controller driving a self-timed 64x4 nibble FIFO
// Assumes: FIFO pins are asynchronous, synchronised here
// Notes: Writes pass an 8-word buffer before the FIFO load port
`timescale 1ns/10ps
`include "snf_defs.vh"
module snf_host_ctrl
(
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // User write stream
   input wire wrValid,
   output wire wrReady,
   input wire [`SNF_WORD_W-1:0] wrData,
   // User read stream
   output reg rdValid,
   input wire rdReady,
   output reg [`SNF_WORD_W-1:0] rdData,
   // FIFO load side pins
   output reg loadStrobe,
   output reg [`SNF_WORD_W-1:0] write_nibble,
   input wire load_side_ready,
   // FIFO unload side pins
   output reg unloadStrobe,
   input wire [`SNF_WORD_W-1:0] read_nibble,
   input wire outputValid,
   // Status
   output reg transitTimeout
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg [1:0] rdySync;
   reg [1:0] ovSync;
   reg [`SNF_WORD_W-1:0] rdSync0;
   reg [`SNF_WORD_W-1:0] rdSync1;
   wire rdyS = rdySync[1];
   wire ovS = ovSync[1];
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         rdySync <= 2'h0;
         ovSync <= 2'h0;
         rdSync0 <= 4'h0;
         rdSync1 <= 4'h0;
      end
      else
      begin
         rdySync <= {rdySync[0], load_side_ready};
         ovSync <= {ovSync[0], outputValid};
         rdSync0 <= read_nibble;
         rdSync1 <= rdSync0;
      end
   end

   // ----------------------------------------
   // Write buffer
   // ----------------------------------------
   wire bufValid;
   wire [`SNF_WORD_W-1:0] bufData;
   reg bufTake;
   snf_stream_buffer #(
      .WIDTH(`SNF_WORD_W),
      .DEPTH(`SNF_BUF_DEPTH),
      .AW(`SNF_BUF_AW)
   ) uBuf (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .inValid(wrValid),
      .inReady(wrReady),
      .inData(wrData),
      .outValid(bufValid),
      .outReady(bufTake),
      .outData(bufData)
   );

   // ----------------------------------------
   // Load handshake
   // ----------------------------------------
   localparam [2:0] L_IDLE = 3'h1;
   localparam [2:0] L_HIGH = 3'h2;
   localparam [2:0] L_LOW = 3'h4;
   reg [2:0] lState;
   reg [2:0] next_lState;
   always @*
   begin
      next_lState = lState;
      bufTake = 1'b0;
      case (lState)
         L_IDLE:
         begin
            // Start only once load-ready is back high
            if (bufValid && rdyS)
            begin
               next_lState = L_HIGH;
               bufTake = 1'b1;
            end
         end
         L_HIGH:
         begin
            if (!rdyS)
            begin
               next_lState = L_LOW;
            end
         end
         L_LOW:
         begin
            next_lState = L_IDLE;
         end
         default:
         begin
            next_lState = L_IDLE;
         end
      endcase
   end
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         lState <= L_IDLE;
         loadStrobe <= 1'b0;
         write_nibble <= 4'h0;
      end
      else
      begin
         lState <= next_lState;
         if (bufTake)
         begin
            write_nibble <= bufData;
            loadStrobe <= 1'b1;
         end
         else if (lState == L_HIGH && !rdyS)
         begin
            loadStrobe <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Unload handshake
   // ----------------------------------------
   localparam [2:0] U_IDLE = 3'h1;
   localparam [2:0] U_HIGH = 3'h2;
   localparam [2:0] U_WAIT = 3'h4;
   reg [2:0] uState;
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         uState <= U_IDLE;
         unloadStrobe <= 1'b0;
         rdValid <= 1'b0;
         rdData <= 4'h0;
      end
      else
      begin
         if (rdValid && rdReady)
         begin
            rdValid <= 1'b0;
         end
         case (uState)
            U_IDLE:
            begin
               // Valid low means empty: no unload
               if (ovS && !(rdValid && !rdReady))
               begin
                  rdData <= rdSync1;
                  rdValid <= 1'b1;
                  unloadStrobe <= 1'b1;
                  uState <= U_HIGH;
               end
            end
            U_HIGH:
            begin
               if (!ovS)
               begin
                  unloadStrobe <= 1'b0;
                  uState <= U_WAIT;
               end
            end
            U_WAIT:
            begin
               uState <= U_IDLE;
            end
            default:
            begin
               uState <= U_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Transit watchdog
   // ----------------------------------------
   // Flags data loaded but nothing visible after the longest transit
   reg [`SNF_CNT_W-1:0] transitCnt;
   reg [6:0] held;
   wire loadDone = (lState == L_LOW);
   wire unloadDone = (uState == U_WAIT);
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         held <= 7'h00;
         transitCnt <= 11'h000;
         transitTimeout <= 1'b0;
      end
      else
      begin
         if (loadDone && !unloadDone)
         begin
            held <= held + 7'h01;
         end
         else if (unloadDone && !loadDone && held != 7'h00)
         begin
            held <= held - 7'h01;
         end
         if (held == 7'h00 || ovS)
         begin
            transitCnt <= 11'h000;
         end
         else if (transitCnt != `SNF_TRANSIT_MAX_CYC)
         begin
            transitCnt <= transitCnt + 11'h001;
         end
         if (transitCnt == `SNF_TRANSIT_MAX_CYC)
         begin
            transitTimeout <= 1'b1;
         end
         else if (ovS)
         begin
            transitTimeout <= 1'b0;
         end
      end
   end
endmodule

// ---- testbench/snf_pin_chk_sva.sv ----
// Purpose: Handshake checks on the FIFO pins
// Assumes: Device pins move on core_clk
// Notes: Bound in tb
`timescale 1ns/10ps
module snf_pin_chk
(
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // FIFO pins
   input wire loadStrobe,
   input wire load_side_ready,
   input wire unloadStrobe,
   input wire outputValid
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   chk_load_needs_ready: assert property ($rose(loadStrobe) |-> load_side_ready)
      else $error("load strobe without ready");
   chk_load_strobe_drop: assert property (loadStrobe && $fell(load_side_ready) |-> ##[1:5] !loadStrobe)
      else $error("load strobe stuck");
   chk_unload_needs_valid: assert property ($rose(unloadStrobe) |-> outputValid)
      else $error("unload strobe without valid");
   chk_unload_strobe_drop: assert property (unloadStrobe && $fell(outputValid) |-> ##[1:5] !unloadStrobe)
      else $error("unload strobe stuck");
endmodule

// ---- testbench/snf_fifo_model.sv ----
// Purpose: Behavioural 64x4 self-timed FIFO
// Assumes: Pins sampled on core_clk
// Notes: Words reach the output at once
`timescale 1ns/10ps
module snf_fifo_model #(parameter SETTLE = 10, parameter DEPTH = 64)
(
   // Clock and reset
   input wire core_clk,
   input wire sys_rst,
   // Load side
   input wire loadStrobe,
   input wire [3:0] write_nibble,
   output reg load_side_ready,
   // Unload side
   input wire unloadStrobe,
   output reg [3:0] read_nibble,
   output reg outputValid
);
   logic [3:0] cells[$];
   logic [3:0] inCell;
   logic held;
   logic taken;
   int settle;
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         cells = {};
         held <= 1'h0;
         taken <= 1'h0;
         settle <= 0;
         load_side_ready <= 1'h1;
         outputValid <= 1'h0;
         read_nibble <= 4'h5;
      end
      else
      begin
         if (load_side_ready && loadStrobe && !held)
         begin
            inCell <= write_nibble;
            held <= 1'h1;
            settle <= SETTLE;
         end
         if (held && settle > 0)
            settle <= settle - 1;
         if (held && settle == 1)
            load_side_ready <= 1'h0;
         if (held && !load_side_ready && !loadStrobe && cells.size() < DEPTH - 1)
         begin
            cells.push_back(inCell);
            held <= 1'h0;
            load_side_ready <= 1'h1;
         end
         if (outputValid && unloadStrobe)
         begin
            outputValid <= 1'h0;
            taken <= 1'h1;
            void'(cells.pop_front());
         end
         else if (taken && !unloadStrobe)
            taken <= 1'h0;
         else if (!outputValid && !taken && cells.size() > 0)
         begin
            outputValid <= 1'h1;
            read_nibble <= cells[0];
         end
         else if (!outputValid && !taken)
            read_nibble <= ~read_nibble;
      end
   end
endmodule

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for the host controller
// Assumes: Device modelled on core_clk
// Notes: No random stimulus
`timescale 1ns/10ps
module tb;
   logic core_clk = 0;
   logic sys_rst = 1;
   logic wrValid = 0;
   logic rdReady = 0;
   logic [3:0] wrData = 4'h0;
   wire wrReady, rdValid, loadStrobe, load_side_ready, unloadStrobe, outputValid, transitTimeout;
   wire [3:0] rdData, write_nibble, read_nibble;
   int n_errors = 0;
   int check_count = 0;
   int nIn = 0;
   int nOut = 0;
   snf_host_ctrl i_snf_host_ctrl (.core_clk, .sys_rst, .wrValid, .wrReady, .wrData, .rdValid, .rdReady,
      .rdData, .loadStrobe, .write_nibble, .load_side_ready, .unloadStrobe, .read_nibble, .outputValid,
      .transitTimeout);
   snf_fifo_model i_snf_fifo_model (.core_clk, .sys_rst, .loadStrobe, .write_nibble, .load_side_ready,
      .unloadStrobe, .read_nibble, .outputValid);
   initial
   begin
      forever #12.5 core_clk = ~core_clk;
   end
   task check(input logic [3:0] seen, input logic [3:0] exp);
   begin
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task push(input int n);
   begin
      repeat (n)
      begin
         @(negedge core_clk);
         wrValid = 1;
         wrData = nIn[3:0];
         while (wrReady !== 1'h1)
            @(negedge core_clk);
         nIn++;
      end
      @(negedge core_clk);
      wrValid = 0;
   end
   endtask
   task pop(input int n);
   begin
      repeat (n)
      begin
         @(negedge core_clk);
         while (rdValid !== 1'h1)
            @(negedge core_clk);
         check(rdData, nOut[3:0]);
         nOut++;
         rdReady = 1;
         @(negedge core_clk);
         rdReady = 0;
      end
   end
   endtask
   task t_reset;
   begin
      repeat (6) @(negedge core_clk);
      sys_rst = 0;
      repeat (3) @(negedge core_clk);
      check({3'h0, load_side_ready}, 4'h1);
      check({3'h0, outputValid}, 4'h0);
      check({3'h0, wrReady}, 4'h1);
      check({3'h0, rdValid}, 4'h0);
      check({3'h0, loadStrobe}, 4'h0);
      check({3'h0, unloadStrobe}, 4'h0);
   end
   endtask
   task t_order;
   begin
      push(20);
      pop(20);
      repeat (20) @(negedge core_clk);
      check({3'h0, outputValid}, 4'h0);
      check({3'h0, rdValid}, 4'h0);
      check({3'h0, unloadStrobe}, 4'h0);
   end
   endtask
   task t_full;
   begin
      push(73);
      repeat (60) @(negedge core_clk);
      check({3'h0, load_side_ready}, 4'h0);
      check({3'h0, wrReady}, 4'h0);
      check({3'h0, outputValid}, 4'h1);
      pop(73);
      repeat (20) @(negedge core_clk);
      check({3'h0, outputValid}, 4'h0);
      check({3'h0, load_side_ready}, 4'h1);
      check({3'h0, transitTimeout}, 4'h0);
   end
   endtask
   task tally_and_finish;
   begin
      if (n_errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   initial
   begin
      t_reset;
      t_order;
      t_full;
      tally_and_finish;
   end
   initial
   begin
      #250000;
      n_errors++;
      tally_and_finish;
   end
endmodule
bind snf_host_ctrl snf_pin_chk i_snf_pin_chk (.core_clk(core_clk), .sys_rst(sys_rst), .loadStrobe(loadStrobe),
   .load_side_ready(load_side_ready), .unloadStrobe(unloadStrobe), .outputValid(outputValid));
